// ==== src/gdic_pkg.sv ====
package gdic_pkg;

	// Serial frame length in bits, and the width of its bit counter.
	localparam int unsigned FRAME_BITS = 16;
	localparam int unsigned FRAME_CNT_W = 5;

	// Fault vector layout: bit 0 is the shoot-through fault, the rest come from outside.
	localparam int unsigned FAULT_W = 8;
	localparam int unsigned FAULT_STP_BIT = 0;

	// Converter result width, which also sets the duty-cycle output resolution.
	localparam int unsigned ADC_W = 10;

	// Host-side timing limits, kept for reference by the bench.
	localparam int unsigned SERIAL_CLK_MAX_HZ = 4000000;
	localparam int unsigned PWM_MIN_HZ = 1000;
	localparam int unsigned PWM_MAX_HZ = 50000;

	// Reset values of the pin-side outputs.
	localparam logic RST_FAULT_ALARM_N = 1'b1;
	localparam logic RST_WARNING_N = 1'b1;
	localparam logic RST_PULLUP = 1'b0;
	localparam logic RST_PULLDOWN = 1'b0;
	localparam logic RST_SDO = 1'b0;

	// Drive selection for the gate stage.
	typedef enum logic [1:0] {
		GDIC_DRV_OFF = 2'b00,
		GDIC_DRV_PWM = 2'b01,
		GDIC_DRV_FORCE = 2'b11
	} gdic_drive_e;

endpackage : gdic_pkg

// ==== src/gdic_sync.sv ====
module gdic_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_reg;

	// The first stage feeds only the second stage.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stage1_reg <= RST_VAL;
			syncOut <= RST_VAL;
		end else begin
			stage1_reg <= asyncIn;
			syncOut <= stage1_reg;
		end
	end

endmodule : gdic_sync

// ==== src/gdic_top.sv ====
module gdic_top
	import gdic_pkg::*;
#(
	parameter int unsigned N_FAULT = FAULT_W,
	parameter int unsigned N_ADC = ADC_W
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pwmPos,
	input wire logic pwmNeg,
	input wire logic shortCircuitForceEnable,
	input wire logic shortCircuitForceLevel,
	input wire logic analogInputFive,
	input wire logic analogInputSix,
	input wire logic serialClk,
	input wire logic serialSelectN,
	input wire logic serialDataIn,
	input wire logic driverEnable,
	input wire logic aiFiveForceEnableSel,
	input wire logic aiSixForceLevelSel,
	input wire logic [N_FAULT-1:0] faultIn,
	input wire logic [N_FAULT-1:0] faultMask,
	input wire logic [N_FAULT-1:0] warningAssign,
	input wire logic warningPwmMode,
	input wire logic [N_ADC-1:0] adcValue,
	input wire logic adcRefInternalOff,
	input wire logic [FRAME_BITS-1:0] txWord,
	output logic gatePullupOutput,
	output logic gatePulldownOutput,
	output logic shootThroughFault,
	output logic faultAlarmN,
	output logic warningOutN,
	output logic adcRefEnable,
	output logic serialDataOut,
	output logic [FRAME_BITS-1:0] rxWord,
	output logic rxValid
);

	localparam int unsigned N_PIN = 8;

	logic [N_PIN-1:0] pinSync;
	logic pwmPosS;
	logic pwmNegS;
	logic forceEnS;
	logic forceLvlS;
	logic aiFiveS;
	logic aiSixS;
	logic sclkS;
	logic selNS;

	logic sclkPrev_reg;
	logic selNPrev_reg;
	logic sdiPrev_reg;
	logic [FRAME_BITS-1:0] rxShift_reg;
	logic [FRAME_BITS-1:0] txShift_reg;
	logic [FRAME_CNT_W-1:0] bitCnt_reg;
	logic [N_ADC-1:0] pwmCnt_reg;

	logic sclkRise;
	logic sclkFall;
	logic selFall;
	logic selRise;
	logic forceActive;
	logic forceLevel;
	logic overlap;
	logic [N_FAULT-1:0] faultVec;
	logic [N_FAULT-1:0] faultLive;
	gdic_drive_e driveSel;

	// Select is the lowest bit and idles high, so its stages reset high and no false edge follows reset.
	gdic_sync #(
		.WIDTH(N_PIN),
		.RST_VAL(N_PIN'(1))
	) u_pinSync (
		.mclk(mclk),
		.rst_n(rst_n),
		.asyncIn({pwmPos, pwmNeg, shortCircuitForceEnable, shortCircuitForceLevel,
			analogInputFive, analogInputSix, serialClk, serialSelectN}),
		.syncOut(pinSync)
	);

	assign {pwmPosS, pwmNegS, forceEnS, forceLvlS, aiFiveS, aiSixS, sclkS, selNS} = pinSync;

	// Serial data is sampled through its own pair of flip-flops, aligned with the clock.
	logic sdiSync1_reg;
	logic sdiS;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sdiSync1_reg <= 1'b0;
			sdiS <= 1'b0;
		end else begin
			sdiSync1_reg <= serialDataIn;
			sdiS <= sdiSync1_reg;
		end
	end

	// Gate drive selection.
	always_comb begin
		forceActive = forceEnS | (aiFiveForceEnableSel & aiFiveS);
		if (!forceEnS && aiSixForceLevelSel) begin
			forceLevel = aiSixS;
		end else begin
			forceLevel = forceLvlS;
		end
		if (forceActive) begin
			driveSel = GDIC_DRV_FORCE;
		end else if (driverEnable) begin
			driveSel = GDIC_DRV_PWM;
		end else begin
			driveSel = GDIC_DRV_OFF;
		end
	end

	// Pull-up output high sources the gate.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gatePullupOutput <= RST_PULLUP;
		end else begin
			case (driveSel)
				GDIC_DRV_FORCE: begin
					gatePullupOutput <= forceLevel;
				end
				GDIC_DRV_PWM: begin
					gatePullupOutput <= pwmPosS;
				end
				default: begin
					gatePullupOutput <= 1'b0;
				end
			endcase
		end
	end

	// Pull-down output low sinks the gate; high releases it.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gatePulldownOutput <= RST_PULLDOWN;
		end else begin
			case (driveSel)
				GDIC_DRV_FORCE: begin
					gatePulldownOutput <= forceLevel;
				end
				GDIC_DRV_PWM: begin
					gatePulldownOutput <= pwmPosS;
				end
				default: begin
					gatePulldownOutput <= 1'b0;
				end
			endcase
		end
	end

	// Shoot-through detection and fault outputs.
	assign overlap = pwmPosS & pwmNegS;

	always_comb begin
		faultVec = faultIn;
		faultVec[FAULT_STP_BIT] = overlap;
		faultLive = faultVec & ~faultMask;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			shootThroughFault <= 1'b0;
		end else begin
			shootThroughFault <= overlap;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			faultAlarmN <= RST_FAULT_ALARM_N;
		end else begin
			faultAlarmN <= ~(|faultLive);
		end
	end

	// Free-running duty-cycle counter for the warning output in PWM mode.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pwmCnt_reg <= '0;
		end else begin
			pwmCnt_reg <= pwmCnt_reg + N_ADC'(1);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			warningOutN <= RST_WARNING_N;
		end else if (warningPwmMode) begin
			warningOutN <= (pwmCnt_reg < adcValue);
		end else begin
			warningOutN <= ~(|(faultLive & warningAssign));
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			adcRefEnable <= 1'b1;
		end else begin
			adcRefEnable <= ~adcRefInternalOff;
		end
	end

	// Serial slave: edges of the sampled clock and select.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclkPrev_reg <= 1'b0;
		end else begin
			sclkPrev_reg <= sclkS;
		end
	end

	// Select history resets to its idle level, like its synchroniser stages.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			selNPrev_reg <= 1'b1;
		end else begin
			selNPrev_reg <= selNS;
		end
	end

	// One system clock of data history, so the bit taken is the one that stood before the edge.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sdiPrev_reg <= 1'b0;
		end else begin
			sdiPrev_reg <= sdiS;
		end
	end

	assign sclkRise = ~selNS & sclkS & ~sclkPrev_reg;
	assign sclkFall = ~selNS & ~sclkS & sclkPrev_reg;
	assign selFall = ~selNS & selNPrev_reg;
	assign selRise = selNS & ~selNPrev_reg;

	// Receive: data that stood before the falling edge is taken.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxShift_reg <= '0;
		end else if (sclkFall && !selFall) begin
			rxShift_reg <= {rxShift_reg[FRAME_BITS-2:0], sdiPrev_reg};
		end
	end

	// The bit count saturates at a full word, so an overlong frame keeps its last word.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bitCnt_reg <= '0;
		end else if (selFall) begin
			bitCnt_reg <= '0;
		end else if (sclkFall && bitCnt_reg != FRAME_CNT_W'(FRAME_BITS)) begin
			bitCnt_reg <= bitCnt_reg + FRAME_CNT_W'(1);
		end
	end

	// A frame is delivered only if select rises after at least a full word.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxWord <= '0;
		end else if (selRise && bitCnt_reg == FRAME_CNT_W'(FRAME_BITS)) begin
			rxWord <= rxShift_reg;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxValid <= 1'b0;
		end else begin
			rxValid <= selRise && bitCnt_reg == FRAME_CNT_W'(FRAME_BITS);
		end
	end

	// Transmit: word loaded at select fall, next bit presented on each rising edge.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txShift_reg <= '0;
			serialDataOut <= RST_SDO;
		end else if (selFall) begin
			txShift_reg <= txWord;
			serialDataOut <= txWord[FRAME_BITS-1];
		end else if (sclkRise) begin
			serialDataOut <= txShift_reg[FRAME_BITS-1];
			txShift_reg <= {txShift_reg[FRAME_BITS-2:0], 1'b0};
		end else if (selNS) begin
			serialDataOut <= RST_SDO;
		end
	end

endmodule : gdic_top

// ==== dv/gdic_top_chk.sv ====
module gdic_top_chk
	import gdic_pkg::*;
#(
	parameter int unsigned N_FAULT = FAULT_W
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pwmPos,
	input wire logic pwmNeg,
	input wire logic shortCircuitForceEnable,
	input wire logic shortCircuitForceLevel,
	input wire logic analogInputFive,
	input wire logic analogInputSix,
	input wire logic serialClk,
	input wire logic serialSelectN,
	input wire logic driverEnable,
	input wire logic aiFiveForceEnableSel,
	input wire logic aiSixForceLevelSel,
	input wire logic [N_FAULT-1:0] faultIn,
	input wire logic [N_FAULT-1:0] faultMask,
	input wire logic [N_FAULT-1:0] warningAssign,
	input wire logic warningPwmMode,
	input wire logic gatePullupOutput,
	input wire logic gatePulldownOutput,
	input wire logic shootThroughFault,
	input wire logic faultAlarmN,
	input wire logic warningOutN,
	input wire logic serialDataOut,
	input wire logic rxValid
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_force_high_up: assert property (
		(shortCircuitForceEnable && shortCircuitForceLevel)[*4] |=> gatePullupOutput) else $error("force high lost");
	a_force_low_down: assert property (
		(shortCircuitForceEnable && !shortCircuitForceLevel)[*4] |=> !gatePulldownOutput && !gatePullupOutput)
		else $error("force low lost");
	a_pwm_high_up: assert property (
		(driverEnable && pwmPos && !shortCircuitForceEnable && !aiFiveForceEnableSel)[*4]
		|=> gatePullupOutput && gatePulldownOutput) else $error("pwm high not driven");
	a_pwm_low_down: assert property (
		(driverEnable && !pwmPos && !shortCircuitForceEnable && !aiFiveForceEnableSel)[*4]
		|=> !gatePulldownOutput) else $error("pwm low not driven");
	a_off_holds_low: assert property (
		(!driverEnable && !shortCircuitForceEnable && !aiFiveForceEnableSel)[*4]
		|=> !gatePulldownOutput && !gatePullupOutput) else $error("idle gate wrong");
	a_ai_five_force: assert property (
		(aiFiveForceEnableSel && analogInputFive && !shortCircuitForceEnable && aiSixForceLevelSel && analogInputSix)[*4]
		|=> gatePullupOutput) else $error("secondary force lost");
	a_stp_level: assert property (
		(pwmPos && pwmNeg)[*4] |=> shootThroughFault) else $error("overlap not flagged");
	a_alarm_on_fault: assert property (
		|(faultIn & ~faultMask & 8'hfe) |=> !faultAlarmN) else $error("alarm not low");
	a_warn_on_fault: assert property (
		!warningPwmMode && |(faultIn & ~faultMask & warningAssign & 8'hfe) |=> !warningOutN)
		else $error("warning not low");
	a_rx_after_select: assert property (
		rxValid |-> serialSelectN && $past(serialSelectN, 2)) else $error("frame without select");
	a_sdo_on_rise: assert property (
		$changed(serialDataOut) && !serialSelectN && !$past(serialSelectN, 6) |-> $past(serialClk, 3))
		else $error("sdo moved off rise");
endmodule : gdic_top_chk

bind gdic_top gdic_top_chk #(.N_FAULT(N_FAULT)) chk_u (.*);

// ==== dv/gdic_host.sv ====
module gdic_host (
	input wire logic start,
	input wire logic junk,
	input wire logic [15:0] hostWord,
	input wire logic serialDataOut,
	output logic serialClk,
	output logic serialSelectN,
	output logic serialDataIn,
	output logic done,
	output logic [15:0] capWord
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		serialClk = 1'h0;
		serialSelectN = 1'h1;
		serialDataIn = 1'h0;
		done = 1'h0;
		capWord = 16'h0000;
	end
	// A junk frame keeps select high to show the clock is ignored.
	always @(posedge start) begin
		#203 serialSelectN = junk;
		// The link runs fast on purpose; each half period still spans six system clocks.
		for (int i = 15; i >= 0; i--) begin
			#62.5 serialClk = 1'h1;
			serialDataIn = hostWord[i];
			#62.5 capWord = {capWord[14:0], serialDataOut};
			serialClk = 1'h0;
		end
		#100 serialSelectN = 1'h1;
		serialDataIn = ~serialDataIn;
		done = 1'h1;
		#20 done = 1'h0;
	end
endmodule : gdic_host

// ==== dv/gdic_top_tb.sv ====
module gdic_top_tb
	import gdic_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 0, rst_n = 0, pwmPos = 0, pwmNeg = 0, shortCircuitForceEnable = 0, shortCircuitForceLevel = 0;
	logic analogInputFive = 0, analogInputSix = 0, driverEnable = 0, aiFiveForceEnableSel = 0;
	logic aiSixForceLevelSel = 0, warningPwmMode = 0, adcRefInternalOff = 0, start = 0, junk = 0;
	logic [FAULT_W-1:0] faultIn = 8'h00, faultMask = 8'h00, warningAssign = 8'h00;
	logic [ADC_W-1:0] adcValue = 10'h000;
	logic [FRAME_BITS-1:0] txWord = 16'h3c5a, hostWord = 16'h0000, rxWord, capWord, hi;
	logic gatePullupOutput, gatePulldownOutput, shootThroughFault, faultAlarmN, warningOutN;
	logic adcRefEnable, serialDataOut, rxValid, serialClk, serialSelectN, serialDataIn, done;
	int err_total = 0, num_checks = 0, cyc = 0, nValid = 0;
	localparam int PWM_HALF = 100000000 / PWM_MAX_HZ / 2;
	always #5 mclk = ~mclk;
	gdic_top dut_u (.*);
	gdic_host host_u (.*);
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task settle;
		repeat (6) @(posedge mclk);
		#1;
	endtask : settle
	task frame(input logic [15:0] w, input logic j);
		@(posedge mclk) hostWord <= w;
		junk <= j;
		start <= 1'h1;
		@(posedge mclk) start <= 1'h0;
		for (int i = 0; i < 900 && done !== 1'h1; i++) @(posedge mclk);
		chk("frameDone", {15'h0000, done}, 16'h0001);
		settle();
	endtask : frame
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		nValid <= nValid + (rxValid === 1'h1);
		if (cyc == 10000) begin
			err_total++;
			finish_test();
		end
	end
	initial begin
		@(posedge mclk) #1;
		chk("rstUp", {gatePullupOutput, gatePulldownOutput, serialDataOut}, 16'h0000);
		chk("rstFlags", {faultAlarmN, warningOutN, adcRefEnable}, 16'h0007);
		@(posedge mclk) rst_n <= 1'h1;
		settle();
		chk("offGate", {gatePullupOutput, gatePulldownOutput}, 16'h0000);
		@(posedge mclk) {driverEnable, pwmPos} <= 2'h3;
		settle();
		chk("pwmHigh", {gatePullupOutput, gatePulldownOutput}, 16'h0003);
		@(posedge mclk) pwmPos <= 1'h0;
		settle();
		chk("pwmLow", {gatePullupOutput, gatePulldownOutput}, 16'h0000);
		@(posedge mclk) {shortCircuitForceEnable, shortCircuitForceLevel} <= 2'h3;
		settle();
		chk("forceHigh", gatePullupOutput, 16'h0001);
		@(posedge mclk) {shortCircuitForceLevel, pwmPos} <= 2'h1;
		settle();
		chk("forceLow", {gatePullupOutput, gatePulldownOutput}, 16'h0000);
		@(posedge mclk) {shortCircuitForceEnable, pwmPos} <= 2'h0;
		{aiFiveForceEnableSel, analogInputFive, aiSixForceLevelSel, analogInputSix} <= 4'hf;
		settle();
		chk("aiForceHigh", gatePullupOutput, 16'h0001);
		@(posedge mclk) {analogInputSix, pwmPos} <= 2'h1;
		settle();
		chk("aiForceLow", {gatePullupOutput, gatePulldownOutput}, 16'h0000);
		@(posedge mclk) {aiFiveForceEnableSel, analogInputFive, pwmNeg} <= 3'h1;
		settle();
		chk("overlap", {shootThroughFault, faultAlarmN}, 16'h0002);
		@(posedge mclk) faultMask <= 8'h01;
		settle();
		chk("maskedAlarm", faultAlarmN, 16'h0001);
		@(posedge mclk) {pwmNeg, faultIn} <= 9'h008;
		settle();
		chk("faultOut", {faultAlarmN, warningOutN}, 16'h0001);
		@(posedge mclk) warningAssign <= 8'h08;
		settle();
		chk("warnOut", warningOutN, 16'h0000);
		@(posedge mclk) {faultMask, adcRefInternalOff, warningPwmMode} <= 10'h026;
		settle();
		chk("maskAll", {faultAlarmN, warningOutN, adcRefEnable}, 16'h0006);
		foreach (hi[k]) if (k < 3) begin
			@(posedge mclk) adcValue <= (k == 0) ? 10'h000 : ((k == 1) ? 10'h100 : 10'h3ff);
			warningPwmMode <= 1'h1;
			settle();
			hi = 16'h0000;
			repeat (1024) @(negedge mclk) hi = hi + warningOutN;
			chk("duty", hi, {6'h00, adcValue});
		end
		frame(16'ha5c3, 1'h0);
		chk("rxWord", rxWord, 16'ha5c3);
		chk("txWord", capWord, txWord);
		frame(16'h5a3c, 1'h1);
		chk("ignored", {rxWord[14:0], 1'(nValid)}, 16'h4b87);
		frame(16'h5a3c, 1'h0);
		chk("rxWord2", rxWord, 16'h5a3c);
		chk("frames", nValid, 16'h0002);
		@(posedge mclk) pwmPos <= 1'h0;
		settle();
		hi = 16'h0000;
		fork
			for (int t = 0; t < 2 * PWM_HALF; t++) @(posedge mclk) pwmPos <= (t < PWM_HALF);
			repeat (2 * PWM_HALF + 100) @(negedge mclk) hi = hi + gatePullupOutput;
		join
		chk("pwmPeriod", hi, 16'(PWM_HALF));
		finish_test();
	end
endmodule : gdic_top_tb
